/* epa_pkg.sv */
/*
 * epa_pkg: constants, field positions, reset values and carrier types for the
 * eight-bit port a block. Assumes an APB master with 32-bit data and a
 * 125 MHz mclk shared by the whole block.
 */
`default_nettype none
package epa_pkg;
	localparam int ADDR_W = 12;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_PIN_DATA = 8'h05;
	localparam logic [7:0] IDX_DIRECTION = 8'h85;
	localparam logic [7:0] IDX_CMP_CTRL = 8'h9c;
	localparam logic [7:0] IDX_CMP_REF = 8'h9d;
	localparam logic [7:0] IDX_CONV_CTRL = 8'h9f;
	localparam logic [7:0] IDX_OSC_SEL = 8'ha0;
	// reset values
	localparam logic [7:0] RST_DIRECTION = 8'hff;
	localparam logic [7:0] RST_CMP_CTRL = 8'h07;
	localparam logic [7:0] RST_CMP_REF = 8'h00;
	localparam logic [7:0] RST_CONV_CTRL = 8'h00;
	localparam logic [7:0] RST_LATCH = 8'h00;
	// field positions
	localparam int CMP_MODE_LSB = 0;
	localparam int CMP_C1INV_BIT = 4;
	localparam int CMP_C2INV_BIT = 5;
	localparam int CVR_OE_BIT = 6;
	localparam int CVR_EN_BIT = 7;
	localparam logic [7:0] CVR_IMPL_MASK = 8'hef;
	localparam int PCFG_LSB = 0;
	localparam logic [2:0] CMP_MODE_OFF = 3'h7;
	localparam logic [2:0] CMP_MODE_PIN_OUT = 3'h3;
	// pin roles
	localparam int PIN_VREF_OUT = 2;
	localparam int PIN_OPEN_DRAIN = 4;
	localparam int PIN_SLAVE_SEL = 5;
	localparam int PIN_CLK_OUT = 6;
	localparam int PIN_OSC_IN = 7;
	localparam logic [7:0] OSC_PINS_BOTH = 8'hc0;
	localparam logic [7:0] OSC_PIN_IN = 8'h80;
	// pin i is analog while pin_config_field is below its limit; zero: never
	localparam logic [23:0] PCFG_LIMITS = {4'hb, 4'h0, 4'hc, 4'hd, 4'he, 4'hf};

	typedef enum logic [1:0] {
		OSC_BOTH_IO,
		OSC_IN_ONLY,
		OSC_BOTH_OSC,
		OSC_RC_CLKOUT
	} epa_osc_t;
	localparam epa_osc_t RST_OSC_SEL = OSC_BOTH_IO;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} epa_apb_req_t;

	typedef struct packed {
		logic [7:0] pin_s1;
		logic [7:0] pin_s2;
		logic [1:0] cmp_s1;
		logic [1:0] cmp_s2;
		logic [7:0] latch;
		logic [7:0] direction;
		logic [7:0] cmp_ctrl;
		logic [7:0] cmp_ref;
		logic [7:0] conv_ctrl;
		epa_osc_t osc_sel;
		logic osc_prev;
		logic [1:0] osc_div;
		logic [7:0] pin_out;
		logic [7:0] pin_oe_n;
		logic tmr_clk;
		logic slave_sel_n;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} epa_state_t;

	localparam epa_state_t EPA_RST = '{
		pin_s1: 8'h00, pin_s2: 8'h00, cmp_s1: 2'h0, cmp_s2: 2'h0,
		latch: RST_LATCH, direction: RST_DIRECTION, cmp_ctrl: RST_CMP_CTRL,
		cmp_ref: RST_CMP_REF, conv_ctrl: RST_CONV_CTRL, osc_sel: RST_OSC_SEL,
		osc_prev: 1'b0, osc_div: 2'h0, pin_out: 8'h00, pin_oe_n: 8'hff,
		tmr_clk: 1'b0, slave_sel_n: 1'b1, pready: 1'b0, pslverr: 1'b0,
		prdata: 32'h0000_0000};
endpackage : epa_pkg
`default_nettype wire

/* epa_port_a.sv */
/*
 * epa_port_a: eight-bit bidirectional port a with direction, latch,
 * converter and comparator pin selection, oscillator pin sharing, and an
 * APB register slave. Assumes pins and comparator outputs are asynchronous
 * and that the surrounding peripherals run on mclk.
 */
// Decided for this implementation: register access over APB.
`timescale 1ns/1ns
`default_nettype none
module epa_port_a
	import epa_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// apb slave
	input wire epa_apb_req_t apb_req,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pins, enable low while driving
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe_n,
	// alternate functions
	input wire logic comparator_one_output,
	input wire logic comparator_two_output,
	input wire logic ssp_slave_select_en,
	output logic timer_ext_clock_in,
	output logic ssp_slave_select_n
);
	epa_state_t st;
	epa_state_t next_st;

	always_comb begin
		logic [7:0] analog;
		logic [7:0] osc_owned;
		logic [7:0] digital;
		logic [7:0] force_out;
		logic [7:0] force_in;
		logic [7:0] force_val;
		logic [7:0] drive_en;
		logic [7:0] drive_val;
		logic [1:0] cmp_eff;
		logic [3:0] pcfg;
		logic [3:0] limit;
		logic access;
		logic mapped;
		logic [7:0] rd;
		logic [7:0] wd;
		analog = 8'h00;
		osc_owned = 8'h00;
		digital = 8'h00;
		force_out = 8'h00;
		force_in = 8'h00;
		force_val = 8'h00;
		drive_en = 8'h00;
		drive_val = 8'h00;
		cmp_eff = 2'h0;
		pcfg = 4'h0;
		limit = 4'h0;
		access = 1'b0;
		mapped = 1'b0;
		rd = 8'h00;
		wd = 8'h00;
		next_st = st;

		// two-stage synchronisers; only the second stage is read below
		next_st.pin_s1 = pin_in;
		next_st.pin_s2 = st.pin_s1;
		next_st.cmp_s1 = {comparator_two_output, comparator_one_output};
		next_st.cmp_s2 = st.cmp_s1;

		// comparator results after the inversion bits
		cmp_eff[0] = st.cmp_s2[0] ^ st.cmp_ctrl[CMP_C1INV_BIT];
		cmp_eff[1] = st.cmp_s2[1] ^ st.cmp_ctrl[CMP_C2INV_BIT];

		// analog selection from the converter field; reset value 0 makes pins 0 to 3 and 5 analog
		pcfg = st.conv_ctrl[PCFG_LSB +: 4];
		for (int i = 0; i < 6; i++) begin
			limit = PCFG_LIMITS[i*4 +: 4];
			analog[i] = (pcfg < limit);
		end
		if (st.cmp_ctrl[CMP_MODE_LSB +: 3] != CMP_MODE_OFF) begin
			analog[3:0] = 4'hf;
		end
		if (st.cmp_ref[CVR_EN_BIT] && st.cmp_ref[CVR_OE_BIT]) begin
			analog[PIN_VREF_OUT] = 1'b1;
		end

		// oscillator pin ownership
		unique case (st.osc_sel)
			OSC_BOTH_IO: osc_owned = 8'h00;
			OSC_IN_ONLY: osc_owned = OSC_PIN_IN;
			OSC_BOTH_OSC: osc_owned = OSC_PINS_BOTH;
			OSC_RC_CLKOUT: osc_owned = OSC_PINS_BOTH;
		endcase
		digital = ~(analog | osc_owned);

		// divide the oscillator input by four for the rc clock out
		next_st.osc_prev = st.pin_s2[PIN_OSC_IN];
		if (st.osc_sel != OSC_RC_CLKOUT) begin
			next_st.osc_div = 2'h0;
		end else if (st.pin_s2[PIN_OSC_IN] && !st.osc_prev) begin
			next_st.osc_div = st.osc_div + 2'h1;
		end

		// peripheral overrides of direction
		if (st.cmp_ctrl[CMP_MODE_LSB +: 3] == CMP_MODE_PIN_OUT) begin
			force_out[PIN_OPEN_DRAIN] = 1'b1;
			force_val[PIN_OPEN_DRAIN] = cmp_eff[0];
			force_out[PIN_SLAVE_SEL] = 1'b1;
			force_val[PIN_SLAVE_SEL] = cmp_eff[1];
		end
		if (st.osc_sel == OSC_RC_CLKOUT) begin
			force_out[PIN_CLK_OUT] = 1'b1;
			force_val[PIN_CLK_OUT] = st.osc_div[1];
		end
		if (ssp_slave_select_en) begin
			force_in[PIN_SLAVE_SEL] = 1'b1;
		end
		// oscillator pins are not driven by the port logic, except the clock out pin in OSC_RC_CLKOUT
		force_in = force_in | (osc_owned & ~force_out);

		// driver enables: direction governs even analog pins
		for (int i = 0; i < 8; i++) begin
			drive_en[i] = (!st.direction[i] && !force_in[i]) || force_out[i];
			drive_val[i] = force_out[i] ? force_val[i] : st.latch[i];
		end
		next_st.pin_out = drive_val;
		next_st.pin_oe_n = ~drive_en;
		// open drain: only ever pulls low
		next_st.pin_out[PIN_OPEN_DRAIN] = 1'b0;
		next_st.pin_oe_n[PIN_OPEN_DRAIN] = !(drive_en[PIN_OPEN_DRAIN]
			&& !drive_val[PIN_OPEN_DRAIN]);

		// timer clock and slave select taken from synchronised pins
		next_st.tmr_clk = st.pin_s2[PIN_OPEN_DRAIN];
		// an analog pin reads low, so slave select looks active
		next_st.slave_sel_n = ssp_slave_select_en ?
			(st.pin_s2[PIN_SLAVE_SEL] & digital[PIN_SLAVE_SEL]) : 1'b1;

		// apb slave: answers in the second access cycle
		access = apb_req.psel && apb_req.penable;
		next_st.pready = access && !st.pready;
		next_st.pslverr = 1'b0;
		mapped = 1'b1;
		unique case (apb_req.paddr)
			{2'b00, IDX_PIN_DATA, 2'b00}: rd = st.pin_s2 & digital;
			{2'b00, IDX_DIRECTION, 2'b00}: rd = st.direction & ~osc_owned;
			{2'b00, IDX_CMP_CTRL, 2'b00}: rd = {cmp_eff[1], cmp_eff[0], st.cmp_ctrl[5:0]};
			{2'b00, IDX_CMP_REF, 2'b00}: rd = st.cmp_ref & CVR_IMPL_MASK;
			{2'b00, IDX_CONV_CTRL, 2'b00}: rd = st.conv_ctrl;
			{2'b00, IDX_OSC_SEL, 2'b00}: rd = {6'h00, st.osc_sel};
			default: begin
				rd = 8'h00;
				mapped = 1'b0;
			end
		endcase
		if (access && !st.pready) begin
			next_st.prdata = {24'h000000, rd};
			next_st.pslverr = !mapped;
		end

		// writes take effect at the edge that samples pready high
		wd = apb_req.pwdata[7:0];
		if (access && st.pready && apb_req.pwrite && mapped) begin
			unique case (apb_req.paddr)
				{2'b00, IDX_PIN_DATA, 2'b00}: next_st.latch = wd;
				{2'b00, IDX_DIRECTION, 2'b00}: next_st.direction = wd;
				{2'b00, IDX_CMP_CTRL, 2'b00}: next_st.cmp_ctrl = {2'b00, wd[5:0]};
				{2'b00, IDX_CMP_REF, 2'b00}: next_st.cmp_ref = wd & CVR_IMPL_MASK;
				{2'b00, IDX_CONV_CTRL, 2'b00}: next_st.conv_ctrl = wd;
				{2'b00, IDX_OSC_SEL, 2'b00}: next_st.osc_sel = epa_osc_t'(wd[1:0]);
				default: next_st.latch = st.latch;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st <= EPA_RST;
		end else begin
			st <= next_st;
		end
	end

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign pin_out = st.pin_out;
	assign pin_oe_n = st.pin_oe_n;
	assign timer_ext_clock_in = st.tmr_clk;
	assign ssp_slave_select_n = st.slave_sel_n;
endmodule : epa_port_a
`default_nettype wire

/* epa_chk_properties.sv */
/* epa_chk: assertions on the port a block's ports.
   assumes the epa_port_a ports and one mclk domain. */
`timescale 1ns/1ns
`default_nettype none
module epa_chk
	import epa_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// apb
	input wire epa_apb_req_t apb_req,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// pins
	input wire logic [7:0] pin_in,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe_n,
	input wire logic timer_ext_clock_in
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence setup_s;
		apb_req.psel && !apb_req.penable;
	endsequence
	sequence dir_wr_s;
		pready && apb_req.pwrite && apb_req.paddr == {2'b00, IDX_DIRECTION, 2'b00};
	endsequence
	ready_wait_a: assert property (setup_s |-> ##2 pready)
		else $error("pready late");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held");
	error_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr alone");
	high_zero_a: assert property (pready |-> prdata[31:8] == 24'h000000)
		else $error("upper read bits set");
	drain_low_a: assert property (pin_out[4] == 1'b0)
		else $error("bit four driven high");
	reset_release_a: assert property ($fell(rst) |-> pin_oe_n == 8'hff)
		else $error("pins driven after reset");
	// the synchronisers restart at reset, so only judge after three clean cycles
	timer_follow_a: assert property (!$past(rst, 1) && !$past(rst, 2) && !$past(rst, 3)
		|-> timer_ext_clock_in == $past(pin_in[4], 3)) else $error("timer clock lag");
	dir_apply_a: assert property (dir_wr_s |-> ##2 pin_oe_n[0] == $past(apb_req.pwdata[0], 2))
		else $error("direction not applied");
endmodule : epa_chk
bind epa_port_a epa_chk u_chk (.mclk(mclk), .rst(rst), .apb_req(apb_req), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
	.pin_oe_n(pin_oe_n), .timer_ext_clock_in(timer_ext_clock_in));
`default_nettype wire

/* epa_pin_model.sv */
/* epa_pin_model: board side of the port a pins.
   assumes active-low driver enables; the board drives weakly. */
`timescale 1ns/1ns
`default_nettype none
module epa_pin_model (
	// from the port
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe_n,
	// weak board source, also the pull-up on bit four
	input wire logic [7:0] ext,
	// resolved level
	output logic [7:0] pin_in
);
	assign pin_in = (pin_oe_n & ext) | (~pin_oe_n & pin_out);
endmodule : epa_pin_model
`default_nettype wire

/* testbench.sv */
/* testbench: register and pin tests of epa_port_a.
   assumes apb answers within 20 cycles and the pin model. */
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import epa_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	epa_apb_req_t q = '0;
	logic [31:0] prdata, rdv;
	logic pready, pslverr, erv, tmr, ss_n;
	logic [7:0] pin_in, pin_out, pin_oe_n;
	logic [7:0] ext = 8'hff;
	logic c1 = 1'b0;
	logic c2 = 1'b0;
	logic ss_en = 1'b0;
	logic [7:0] osc_exp [4] = '{8'hff, 8'h7f, 8'h3f, 8'h3f};
	int n_mismatch = 0;
	int total_checks = 0;
	localparam logic [11:0] A_DATA = {2'b00, IDX_PIN_DATA, 2'b00};
	localparam logic [11:0] A_DIR = {2'b00, IDX_DIRECTION, 2'b00};
	localparam logic [11:0] A_CMP = {2'b00, IDX_CMP_CTRL, 2'b00};
	localparam logic [11:0] A_REF = {2'b00, IDX_CMP_REF, 2'b00};
	localparam logic [11:0] A_CONV = {2'b00, IDX_CONV_CTRL, 2'b00};
	localparam logic [11:0] A_OSC = {2'b00, IDX_OSC_SEL, 2'b00};
	always #4 mclk = ~mclk;
	epa_port_a dut (.mclk(mclk), .rst(rst), .apb_req(q), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.comparator_one_output(c1), .comparator_two_output(c2), .ssp_slave_select_en(ss_en),
		.timer_ext_clock_in(tmr), .ssp_slave_select_n(ss_n));
	epa_pin_model pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext(ext), .pin_in(pin_in));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	// request held up to the edge that samples pready; data taken at that edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		q <= '{1'b1, 1'b0, w, a, d};
		@(posedge mclk);
		q.penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1) begin
			n++;
			if (n > 20) begin
				n_mismatch++;
				finish_test;
			end
			@(posedge mclk);
		end
		rdv = prdata;
		erv = pslverr;
		q <= '0;
	endtask : apb
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h00000000);
		chk(rdv, e);
	endtask : rd
	task settle;
		repeat (4) @(negedge mclk);
	endtask : settle
	task finish_test;
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : finish_test
	initial begin
		repeat (3000) @(posedge mclk);
		n_mismatch++;
		finish_test;
	end
	initial begin
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		settle;
		chk(ss_n, 1'b1);
		rd(A_DIR, 32'hff);
		rd(A_CMP, 32'h07);
		rd(A_CONV, 32'h00);
		rd(A_DATA, 32'hd0);
		rd(12'h000, 32'h00);
		chk(erv, 1'b1);
		wr(A_DATA, 32'h5a);
		wr(A_DIR, 32'h00);
		settle;
		chk(pin_oe_n, 8'h10);
		chk(pin_out, 8'h4a);
		chk(tmr, 1'b1);
		rd(A_DATA, 32'h50);
		wr(A_CONV, 32'h0f);
		rd(A_DATA, 32'h5a);
		@(posedge mclk) ext <= 8'h00;
		settle;
		chk(tmr, 1'b0);
		rd(A_DATA, 32'h4a);
		wr(A_CONV, 32'h0d);
		rd(A_DATA, 32'h48);
		wr(A_CONV, 32'h0f);
		wr(A_DIR, 32'hff);
		settle;
		chk(pin_oe_n, 8'hff);
		rd(A_DATA, 32'h00);
		for (int k = 0; k < 4; k++) begin
			wr(A_OSC, 32'(k));
			rd(A_DIR, {24'h000000, osc_exp[k]});
		end
		chk(pin_oe_n[6], 1'b0);
		// two rising edges on the oscillator input make one half period out
		for (int j = 0; j < 4; j++) begin
			@(posedge mclk) ext[7] <= ~ext[7];
			repeat (6) @(posedge mclk);
			chk(pin_out[6], (j >= 2));
		end
		wr(A_OSC, 32'h00);
		@(posedge mclk) c2 <= 1'b1;
		wr(A_CMP, 32'h03);
		settle;
		chk(pin_oe_n, 8'hcf);
		chk(pin_out[5], 1'b1);
		@(posedge mclk) c1 <= 1'b1;
		settle;
		chk(pin_oe_n[4], 1'b1);
		wr(A_CMP, 32'h07);
		@(posedge mclk) ss_en <= 1'b1;
		wr(A_DIR, 32'h00);
		settle;
		chk(ss_n, 1'b0);
		chk(pin_oe_n[5], 1'b1);
		wr(A_REF, 32'hff);
		rd(A_REF, 32'hef);
		@(posedge mclk) rst <= 1'b1;
		@(posedge mclk) rst <= 1'b0;
		settle;
		rd(A_DIR, 32'hff);
		finish_test;
	end
endmodule : testbench
`default_nettype wire
